// file: hdl/startup_consts.svh
// Purpose: constants for service node start-up and destination address filtering
// Assumes: 100 MHz clock; tick counts are programmable ports
// Notes: numbers live here, types live in startup_pkg
// How it works
// - local node id 0x3FFF means broadcast to every node.
// - local node id 0x3FFE means multicast; group chosen by connection id.
// - other ids are unicast; accept only when switch id and node id match.
// - node starts disconnected; hears beacons and sends promotion-needed frames.
// - switch table gains an entry for each beacon from an unrecorded switch, until all 8 entries are used or ST_WAIT is reached.
// - stay in the first band for at least the minimum band-scan time.
// - listen at least the beacon-listen time; random extension at most ten percent.
// - no beacon within listen interval triggers a promotion-needed broadcast.
// - promotion-needed frames use coded differential binary modulation before robust ones.
// - hearing others' promotion-needed frames lowers our own sending rate.
// - send one per max advert period at least, one per min period at most.
// - choosing a switch sends a registration request naming that switch.
// - switch ids are 8 bits, local node ids 14 bits, node id 22 bits.
// - local connection ids are 9 bits and select the multicast group.
`ifndef STARTUP_CONSTS_SVH
`define STARTUP_CONSTS_SVH
`define SWITCH_ID_W 8
`define LOCAL_NODE_ID_W 14
`define NODE_ID_W 22
`define LOCAL_CONN_ID_W 9
`define LOCAL_NODE_ID_BROADCAST 14'h3fff
`define LOCAL_NODE_ID_MULTICAST 14'h3ffe
`define TABLE_DEPTH 8
`define TABLE_IDX_W 3
`define TICK_W 32
`define BACKOFF_MAX 2'h3
`define EXT_MAX_SHIFT 8
`endif

// file: hdl/startup_pkg.sv
// Purpose: types for service node start-up
// Assumes: startup_consts.svh included first
// Notes: none
`include "startup_consts.svh"
package startup_pkg;
	typedef enum logic [2:0] {ST_SCAN, ST_LISTEN, ST_ADVERT, ST_REGISTER, ST_WAIT} phase_t;
	typedef enum logic [1:0] {DEST_NONE, DEST_BCAST, DEST_MCAST, DEST_UCAST} dest_kind_t;
	typedef struct packed {
		phase_t phase;
		logic [`TICK_W-1:0] scan_cnt;
		logic [`TICK_W-1:0] listen_cnt;
		logic [`TICK_W-1:0] adv_cnt;
		logic [1:0] backoff;
		logic robust;
		logic [`TABLE_DEPTH-1:0] valid;
		logic [`TABLE_DEPTH*`SWITCH_ID_W-1:0] sids;
		logic adv_pulse;
		logic reg_pulse;
		logic [`SWITCH_ID_W-1:0] reg_sid;
		dest_kind_t dest_kind;
		logic accept;
		logic [`LOCAL_CONN_ID_W-1:0] group;
		logic beacon_seen;
	} state_t;
endpackage : startup_pkg

// file: hdl/node_startup_addr_filter.sv
// Purpose: disconnected start-up sequencing and destination address classification
// Assumes: all inputs come from logic on clk; tick counts stable while running
// Notes: a band change is left to software, signalled by scan_done
`timescale 1ns/1ps
`include "startup_consts.svh"
module node_startup_addr_filter
	import startup_pkg::*;
(
	input wire logic clk, // 100 MHz clock
	input wire logic rst_b, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic connected, // registration accepted, leave disconnected state
	input wire logic [`TICK_W-1:0] scan_ticks, // min band-scan time in cycles
	input wire logic [`TICK_W-1:0] listen_ticks, // min beacon-listen time in cycles
	input wire logic [`TICK_W-1:0] listen_ext, // random listen extension in cycles
	input wire logic [`TICK_W-1:0] adv_min_ticks, // advert min period in cycles
	input wire logic [`TICK_W-1:0] adv_max_ticks, // advert max period in cycles
	input wire logic robust_ok, // device implements a robust modulation
	input wire logic beacon_valid, // beacon received this cycle
	input wire logic [`SWITCH_ID_W-1:0] beacon_sid, // switch id of received beacon
	input wire logic other_advert, // promotion-needed frame heard from another node
	input wire logic select_valid, // policy picks a table entry
	input wire logic [`TABLE_IDX_W-1:0] select_idx, // chosen table index
	input wire logic rx_valid, // received frame header valid
	input wire logic [`SWITCH_ID_W-1:0] rx_switch_id, // destination switch id
	input wire logic [`LOCAL_NODE_ID_W-1:0] rx_local_node_id, // destination local node id
	input wire logic [`LOCAL_CONN_ID_W-1:0] rx_local_connection_id, // frame connection id
	input wire logic [`NODE_ID_W-1:0] own_node_id, // our node id, switch id on top
	output logic disconnected, // node in disconnected state
	output logic scan_done, // min band-scan time met, band may change
	output logic promotion_needed_frame, // pulse: send promotion-needed broadcast
	output logic advert_robust, // 1: robust format, 0: coded diff binary
	output logic reg_req, // pulse: send registration request
	output logic [`SWITCH_ID_W-1:0] reg_switch_id, // switch named in request
	output logic [`TABLE_DEPTH-1:0] table_valid, // switch table entry valid flags
	output logic [1:0] dest_kind, // 1 bcast, 2 mcast, 3 unicast, 0 none
	output logic dest_accept, // frame is for this node
	output logic [`LOCAL_CONN_ID_W-1:0] dest_group // multicast group
);
	state_t s_r;
	state_t s_nxt;
	logic [`TABLE_DEPTH-1:0] hit;
	logic [`TABLE_DEPTH-1:0] free_oh;
	logic [`TICK_W-1:0] ext_cap;
	logic [`TICK_W-1:0] listen_lim;
	logic [`TICK_W-1:0] adv_lim;
	logic [`SWITCH_ID_W-1:0] own_sid;
	logic [`LOCAL_NODE_ID_W-1:0] own_local_node_id;

	assign own_sid = own_node_id[`NODE_ID_W-1 -: `SWITCH_ID_W];
	assign own_local_node_id = own_node_id[`LOCAL_NODE_ID_W-1:0];
	// cap at about a tenth; shift-add avoids a divider
	assign ext_cap = (listen_ticks >> 4) + (listen_ticks >> 5) + (listen_ticks >> 8);
	assign listen_lim = listen_ticks + ((listen_ext > ext_cap) ? ext_cap : listen_ext);
	// backoff doubles spacing from min, never past max
	always_comb
	begin
		logic [`TICK_W+3:0] scaled;
		scaled = {4'h0, adv_min_ticks} << s_r.backoff;
		if (scaled > {4'h0, adv_max_ticks})
			adv_lim = adv_max_ticks;
		else
			adv_lim = scaled[`TICK_W-1:0];
	end

	genvar g;
	generate
		for (g = 0; g < `TABLE_DEPTH; g++)
		begin : g_tab
			assign hit[g] = s_r.valid[g] && s_r.sids[g*`SWITCH_ID_W +: `SWITCH_ID_W] == beacon_sid;
			assign free_oh[g] = !s_r.valid[g] && ((s_r.valid | ((8'h01 << g) - 8'h01)) ==
				(s_r.valid | ((8'h01 << g) - 8'h01)) && &(s_r.valid | ~((8'h01 << g) - 8'h01)
				| (8'h01 << g)));
		end
	endgenerate

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.adv_pulse = 1'b0;
		s_nxt.reg_pulse = 1'b0;
		if (s_r.scan_cnt < scan_ticks)
			s_nxt.scan_cnt = s_r.scan_cnt + 1'b1;
		if (s_r.adv_cnt != {`TICK_W{1'b1}})
			s_nxt.adv_cnt = s_r.adv_cnt + 1'b1;
		if (beacon_valid)
			s_nxt.beacon_seen = 1'b1;
		// only beacons fill the table, and only before ST_WAIT
		if (beacon_valid && s_r.phase != ST_WAIT && hit == '0 && free_oh != '0)
		begin
			s_nxt.valid = s_r.valid | free_oh;
			for (int i = 0; i < `TABLE_DEPTH; i++)
				if (free_oh[i])
					s_nxt.sids[i*`SWITCH_ID_W +: `SWITCH_ID_W] = beacon_sid;
		end
		if (other_advert && s_r.phase == ST_ADVERT && s_r.backoff != `BACKOFF_MAX)
			s_nxt.backoff = s_r.backoff + 2'h1;
		case (s_r.phase)
			ST_SCAN:
			begin
				s_nxt.listen_cnt = '0;
				if (s_r.scan_cnt >= scan_ticks)
					s_nxt.phase = ST_LISTEN;
			end
			ST_LISTEN:
			begin
				s_nxt.listen_cnt = s_r.listen_cnt + 1'b1;
				if (s_r.beacon_seen || beacon_valid)
					s_nxt.phase = ST_REGISTER;
				else if (s_r.listen_cnt >= listen_lim)
				begin
					s_nxt.phase = ST_ADVERT;
					s_nxt.adv_pulse = 1'b1;
					s_nxt.adv_cnt = '0;
				end
			end
			ST_ADVERT:
			begin
				if (select_valid && s_r.valid[select_idx])
					s_nxt.phase = ST_REGISTER;
				else if (s_r.adv_cnt >= adv_lim && s_r.adv_cnt >= adv_min_ticks)
				begin
					s_nxt.adv_pulse = 1'b1;
					s_nxt.adv_cnt = '0;
					s_nxt.robust = robust_ok; // first frame always coded binary
				end
			end
			ST_REGISTER:
			begin
				if (select_valid && s_r.valid[select_idx])
				begin
					s_nxt.reg_pulse = 1'b1;
					s_nxt.reg_sid = s_r.sids[select_idx*`SWITCH_ID_W +: `SWITCH_ID_W];
					s_nxt.phase = ST_WAIT;
				end
			end
			ST_WAIT: ;
			default: s_nxt.phase = ST_SCAN;
		endcase
		if (connected)
			s_nxt.phase = ST_WAIT;
		// frame classification
		s_nxt.dest_kind = DEST_NONE;
		s_nxt.accept = 1'b0;
		s_nxt.group = '0;
		if (rx_valid)
		begin
			if (rx_local_node_id == `LOCAL_NODE_ID_BROADCAST)
			begin
				s_nxt.dest_kind = DEST_BCAST;
				s_nxt.accept = 1'b1;
			end
			else if (rx_local_node_id == `LOCAL_NODE_ID_MULTICAST)
			begin
				s_nxt.dest_kind = DEST_MCAST;
				s_nxt.accept = 1'b1;
				s_nxt.group = rx_local_connection_id;
			end
			else
			begin
				s_nxt.dest_kind = DEST_UCAST;
				s_nxt.accept = rx_switch_id == own_sid && rx_local_node_id == own_local_node_id;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_r <= '0;
			s_r.phase <= ST_SCAN;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	assign disconnected = s_r.phase != ST_WAIT || !connected;
	assign scan_done = s_r.scan_cnt >= scan_ticks;
	assign promotion_needed_frame = s_r.adv_pulse;
	assign advert_robust = s_r.robust;
	assign reg_req = s_r.reg_pulse;
	assign reg_switch_id = s_r.reg_sid;
	assign table_valid = s_r.valid;
	assign dest_kind = s_r.dest_kind;
	assign dest_accept = s_r.accept;
	assign dest_group = s_r.group;

	first_coded_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(s_r.phase == ST_ADVERT) |-> !advert_robust)
		else $error("first advert not coded binary");
	bcast_accept_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && rx_valid && rx_local_node_id == `LOCAL_NODE_ID_BROADCAST |=> dest_kind == 2'h1 && dest_accept)
		else $error("broadcast not accepted");
	mcast_group_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && rx_valid && rx_local_node_id == `LOCAL_NODE_ID_MULTICAST
		|=> dest_kind == 2'h2 && dest_group == $past(rx_local_connection_id))
		else $error("multicast group wrong");
	ucast_match_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && rx_valid && rx_local_node_id < `LOCAL_NODE_ID_MULTICAST && rx_switch_id != own_sid
		|=> dest_kind == 2'h3 && !dest_accept)
		else $error("foreign unicast accepted");
	reg_names_a: assert property (@(posedge clk) disable iff (!rst_b)
		reg_req |-> table_valid != '0)
		else $error("registration without switch");
	advert_space_a: assert property (@(posedge clk) disable iff (!rst_b)
		promotion_needed_frame && ce |=> !promotion_needed_frame)
		else $error("adverts back to back");
	scan_first_a: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.phase == ST_LISTEN && $past(s_r.phase) == ST_SCAN |-> $past(scan_done))
		else $error("scan cut short");
	listen_min_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(promotion_needed_frame) && $past(s_r.phase) == ST_LISTEN
		|-> $past(s_r.listen_cnt) >= listen_ticks)
		else $error("listen cut short");
endmodule : node_startup_addr_filter

// file: tb/remote_nodes.sv
// Purpose: far-side switch nodes heard by a disconnected node
// Assumes: requests from the bench, one pulse per request
// Notes: beacon_sid toggles between the last id and its inverse every cycle between beacons so stale ids are not trusted
`timescale 1ns/1ps
`include "startup_consts.svh"
module remote_nodes (
	input wire logic clk, // bench clock
	input wire logic rst_b, // async reset, active low
	input wire logic beacon_req, // send a beacon on the next edge
	input wire logic [`SWITCH_ID_W-1:0] req_sid, // switch id for that beacon
	input wire logic advert_req, // send a foreign promotion-needed frame
	output logic beacon_valid, // beacon pulse
	output logic [`SWITCH_ID_W-1:0] beacon_sid, // switch id, only meaningful with the pulse
	output logic other_advert // foreign promotion-needed pulse
);
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			beacon_valid <= 1'b0;
			beacon_sid <= 8'h00;
			other_advert <= 1'b0;
		end
		else
		begin
			beacon_valid <= beacon_req;
			beacon_sid <= beacon_req ? req_sid : ~beacon_sid;
			other_advert <= advert_req;
		end
	end
endmodule : remote_nodes

// file: tb/node_startup_addr_filter_tb_top.sv
// Purpose: self-checking bench for start-up sequencing and address filtering
// Assumes: short tick counts; one clock
// Notes: expected results queue up in the driver, the monitor pops them as outputs appear
`timescale 1ns/1ps
`include "startup_consts.svh"
module node_startup_addr_filter_tb_top;
	import startup_pkg::*;
	localparam logic [7:0] OWN_SID = 8'h54;
	localparam logic [13:0] OWN_LOCAL_NODE_ID = 14'h0a3c;
	logic clk = 1'b0, rst_b = 1'b0, ce = 1'b0, connected = 1'b0, robust_ok = 1'b1;
	logic b_req = 1'b0, a_req = 1'b0, select_valid = 1'b0, rx_valid = 1'b0;
	logic [7:0] b_sid = 8'h00, rx_switch_id = 8'h00;
	logic [2:0] select_idx = 3'h0;
	logic [13:0] rx_local_node_id = 14'h0000;
	logic [8:0] rx_local_connection_id = 9'h000;
	// own id is a bench variable so the unicast match logic sees a driven net, not a tie-off
	logic [21:0] own_node_id = {OWN_SID, OWN_LOCAL_NODE_ID};
	logic beacon_valid, other_advert, disconnected, scan_done, pnf, advert_robust, reg_req;
	logic dest_accept;
	logic [7:0] beacon_sid, reg_switch_id, table_valid;
	logic [1:0] dest_kind;
	logic [8:0] dest_group;
	logic [31:0] aq[$], rq[$], e;
	int err_count = 0, checked = 0, seed = 80, cyc = 0, last_adv = 0, gap_min = 10, n_adv = 0;
	initial forever #5 clk = ~clk;
	remote_nodes remote_nodes_inst (.clk(clk), .rst_b(rst_b), .beacon_req(b_req),
		.req_sid(b_sid), .advert_req(a_req), .beacon_valid(beacon_valid),
		.beacon_sid(beacon_sid), .other_advert(other_advert));
	node_startup_addr_filter node_startup_addr_filter_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
		.connected(connected), .scan_ticks(32'h0000_0014), .listen_ticks(32'h0000_001e),
		.listen_ext(32'h0000_0064), .adv_min_ticks(32'h0000_000a), .adv_max_ticks(32'h0000_0028),
		.robust_ok(robust_ok), .beacon_valid(beacon_valid), .beacon_sid(beacon_sid),
		.other_advert(other_advert), .select_valid(select_valid), .select_idx(select_idx),
		.rx_valid(rx_valid), .rx_switch_id(rx_switch_id), .rx_local_node_id(rx_local_node_id),
		.rx_local_connection_id(rx_local_connection_id), .own_node_id(own_node_id),
		.disconnected(disconnected), .scan_done(scan_done), .promotion_needed_frame(pnf),
		.advert_robust(advert_robust), .reg_req(reg_req), .reg_switch_id(reg_switch_id),
		.table_valid(table_valid), .dest_kind(dest_kind), .dest_accept(dest_accept),
		.dest_group(dest_group));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// monitor: outputs are settled at the falling edge; cyc slightly overcounts, so bounds lean lenient
	always @(negedge clk)
	begin
		if (rst_b)
		begin
			cyc++;
			if (dest_kind !== 2'h0)
			begin
				e = (aq.size() > 0) ? aq.pop_front() : 32'hffff_ffff;
				chk(dest_kind, e[11:10]);
				if (e[11:10] == 2'h2)
					chk(dest_group, e[8:0]);
				else
					chk(dest_accept, e[9]);
			end
			if (reg_req === 1'b1)
				chk(reg_switch_id, (rq.size() > 0) ? rq.pop_front() : 32'hffff_ffff);
			if (pnf === 1'b1)
			begin
				chk(disconnected, 1);
				chk(advert_robust, n_adv > 0);
				if (n_adv == 0)
					chk((cyc >= 50) && (cyc <= 56), 1);
				else
					chk((cyc - last_adv >= gap_min) && (cyc - last_adv <= 40), 1);
				last_adv = cyc;
				n_adv++;
			end
			if (cyc > 3000)
			begin
				err_count++;
				stop_test();
			end
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		ce <= 1'b1;
		@(negedge clk);
		chk({disconnected, scan_done}, 2'h2);
		// back-to-back headers: broadcast, multicast, unicast hit and miss
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk);
			e = $random(seed);
			rx_valid <= 1'b1;
			rx_local_connection_id <= e[8:0];
			rx_switch_id <= (i % 4 == 2) ? OWN_SID : e[23:16];
			rx_local_node_id <= (i % 3 == 0) ? 14'h3fff : (i % 3 == 1) ? 14'h3ffe :
				(i % 4 == 2) ? OWN_LOCAL_NODE_ID : {4'h0, e[31:22]};
			aq.push_back({20'h0_0000, (i % 3 == 0) ? 2'h1 : (i % 3 == 1) ? 2'h2 : 2'h3,
				(i % 3 == 0) || (i % 4 == 2 && i % 3 == 2), e[8:0]});
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		while (cyc < 26)
			@(negedge clk);
		chk(scan_done, 1);
		while (n_adv < 3)
			@(posedge clk);
		a_req <= 1'b1;
		@(posedge clk);
		a_req <= 1'b0;
		while (n_adv < 5)
			@(posedge clk);
		gap_min = 20;
		while (n_adv < 6)
			@(posedge clk);
		// duplicate beacon must not take a second entry
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			b_req <= 1'b1;
			b_sid <= (i == 2) ? 8'h47 : 8'h21;
		end
		@(posedge clk);
		b_req <= 1'b0;
		repeat (3) @(posedge clk);
		chk(table_valid, 8'h03);
		rq.push_back(32'h0000_0047);
		select_valid <= 1'b1;
		select_idx <= 3'h1;
		// first edge leaves the advert phase, second edge issues the request
		repeat (2) @(posedge clk);
		// invalid entry afterwards must be ignored
		select_idx <= 3'h5;
		@(posedge clk);
		select_valid <= 1'b0;
		repeat (6) @(posedge clk);
		chk(rq.size() + aq.size(), 0);
		stop_test();
	end
endmodule : node_startup_addr_filter_tb_top
